// ### testbench/testbench.sv
/* Self-checking bench of the loop sequencer.
 Assumes the pipeline model at its far side. */
`timescale 1ns/10ps
module testbench
   import zls_pkg::*;
;
   logic        clock = 0, nrst = 0, run = 0, cond_true = 0;
   logic        setup_start, push_loop, pop_loop, abort_jump;
   logic        sticky_clear_overflow, reg_rd = 0, reg_wr = 0;
   logic [4:0]  pv = 5'h00;
   localparam logic [4:0] P_SET = 5'h10, P_PUSH = 5'h08, P_POP = 5'h04;
   localparam logic [4:0] P_ABT = 5'h02, P_CLR = 5'h01;
   assign {setup_start, push_loop, pop_loop, abort_jump,
           sticky_clear_overflow} = pv;
   logic [1:0]  reg_sel = 2'h3;
   logic [23:0] setup_pc = 24'h10, setup_end = 24'h15;
   logic [4:0]  setup_code = 5'h0f;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [23:0] exec_pc;
   logic        exec_valid, loop_back, loop_exit, squash, irq_hold;
   logic        count_expired_condition, sticky_overflow, sticky_empty;
   int          mismatches = 0, n_checks = 0, nb, nx, nc, ns, nh;
   always #50 clock = ~clock;
   always @(posedge clock) begin
      nb += loop_back;
      nx += loop_exit;
      nc += count_expired_condition;
      ns += squash;
      nh += irq_hold;
   end
   zls_pipe i_zls_pipe (.clock, .run, .top(setup_pc + 24'h1),
      .end_a(setup_end), .loop_back, .exec_valid, .exec_pc);
   zls_sequencer i_zls_sequencer (.clock, .nrst, .exec_valid, .exec_pc,
      .cond_true, .setup_start, .push_loop, .pop_loop, .abort_jump,
      .setup_pc, .setup_end, .setup_code, .reg_sel, .reg_rd, .reg_wr,
      .reg_wdata, .sticky_clear_overflow, .reg_rdata, .loop_back,
      .loop_exit, .squash, .irq_hold, .count_expired_condition,
      .sticky_overflow, .sticky_empty);
   task automatic chk(logic [31:0] s, logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic acc(logic w, logic [1:0] sel, logic [31:0] d);
      @(posedge clock);
      #5;
      reg_sel = sel;
      reg_wdata = d;
      reg_rd = !w;
      reg_wr = w;
      @(posedge clock);
      #5;
      reg_rd = 0;
      reg_wr = 0;
   endtask
   task automatic rd(logic [1:0] sel, logic [31:0] e, output logic [31:0] v);
      acc(0, sel, 32'h0);
      @(posedge clock);
      #5;
      v = reg_rdata;
      chk(v, e);
   endtask
   // one-cycle pulse on the strobes selected by m
   task automatic pl(logic [4:0] m);
      @(posedge clock);
      #5;
      pv = m;
      @(posedge clock);
      #5;
      pv = 5'h00;
   endtask
   // run the pipeline until an exit or n cycles, then let pulses settle
   task automatic go(int n);
      nb = 0;
      nx = 0;
      nc = 0;
      ns = 0;
      nh = 0;
      run = 1;
      for (int i = 0; i < n && nx == 0; i++) @(posedge clock);
      repeat (3) @(posedge clock);
      #5;
      run = 0;
   endtask
   logic [31:0] v;
   task automatic t_reset;
      rd(2'h0, ALL_ONES, v);
      rd(2'h1, ALL_ONES, v);
      rd(2'h2, NLC_RESET, v);
      rd(2'h3, 32'h0, v);
      chk(sticky_empty, 1);
   endtask
   task automatic t_long;
      acc(1, 2'h2, CNT_THREE);
      pl(P_SET);
      rd(2'h0, {TYPE_CNTN, 1'b0, CODE_COUNT_EXPIRED, 24'h15}, v);
      rd(2'h1, CNT_THREE, v);
      go(60);
      chk(32'(nb), 32'h2);
      chk(32'(nx), 32'h1);
      chk(32'(nc), 32'h1);
      chk(32'(ns), 32'h0);
      rd(2'h1, ALL_ONES, v);
   endtask
   task automatic t_cond;
      setup_code = 5'h01;
      cond_true = 0;
      pl(P_SET);
      rd(2'h0, {TYPE_COND, 1'b0, 5'h01, 24'h15}, v);
      go(2);
      chk(32'(nb), 32'h1);
      chk(32'(nx), 32'h0);
      cond_true = 1;
      go(12);
      chk(32'(nb), 32'h0);
      chk(32'(nx), 32'h1);
      chk(32'(nc), 32'h0);
      cond_true = 0;
      setup_code = CODE_COUNT_EXPIRED;
   endtask
   task automatic t_over;
      acc(1, 2'h2, 32'h5);
      repeat (7) pl(P_PUSH);
      chk(sticky_overflow, 1);
      rd(2'h2, ALL_ONES, v);
      rd(2'h1, 32'h5, v);
      acc(1, 2'h1, 32'h9);
      rd(2'h1, 32'h9, v);
      pl(P_ABT);
      rd(2'h1, 32'h5, v);
      pl(P_CLR);
      chk(sticky_overflow, 0);
      repeat (5) pl(P_POP);
      acc(1, 2'h1, 32'h9);
      rd(2'h1, ALL_ONES, v);
      chk(sticky_empty, 1);
   endtask
   task automatic t_short;
      setup_end = 24'h11;
      acc(1, 2'h2, CNT_ONE);
      pl(P_SET);
      rd(2'h0, {TYPE_CNT1, 1'b0, CODE_COUNT_EXPIRED, 24'h11}, v);
      go(8);
      chk(32'(ns), 32'h1);
      chk(32'(nh), 32'h2);
      chk(32'(nx), 32'h1);
      chk(32'(nc), 32'h1);
      chk(32'(nb), 32'h0);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #400000;
      mismatches++;
      tally_and_finish;
   end
   initial begin
      repeat (20) @(posedge clock);
      #5 nrst = 1;
      t_reset;
      t_long;
      t_cond;
      t_over;
      t_short;
      tally_and_finish;
   end
endmodule

// ### testbench/zls_pipe.sv
/* Pipeline model: executes one address a cycle from the loop top.
 Assumes loop_back comes during the loop, before the end executes. */
`timescale 1ns/10ps
module zls_pipe
   import zls_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              run,
   input  wire logic [ADDR_W-1:0] top,
   input  wire logic [ADDR_W-1:0] end_a,
   input  wire logic              loop_back,
   output logic                   exec_valid,
   output logic      [ADDR_W-1:0] exec_pc
);
   logic pend = 1'b0;
   // never writes counts and keeps loop ends apart
   always_ff @(posedge clock) begin
      exec_valid <= run;
      pend <= (pend || loop_back) && !(exec_pc == end_a && exec_valid);
      if (!run)
         exec_pc <= top;
      else if (exec_valid)
         exec_pc <= (pend && exec_pc == end_a) ? top : exec_pc + 24'h1;
   end
endmodule

// ### verilog/zls_pkg.sv
/*
 Constants, field layouts and state type of the zero overhead loop
 sequencer. Assumes a single core clock and a pipeline that reports the
 address of the instruction now executing.
*/
// Summary of operation
// - one-instruction loops run once or twice, two-instruction loops run once, abort two following instructions
// - interrupts wait one cycle in last short iteration and its NOP
// - one-instruction loop of three or more holds interrupts third-to-last
// - loop abort jump pops both stacks once, one nesting level only
// - three-instruction condition loop tests at top, then one more pass
// - two-instruction condition loop tests at second, one more pass
// - one-instruction condition loop tests every cycle, three more passes
// - six 32-bit address entries: end, code, reserved zero, loop type
// - loop type 00 condition, 01 count len 1, 10 len 2, 11 longer
// - push on setup or loop push, pop at exit (e-2, or the end of one- and two-instruction loops) or loop pop
// - push when full sets sticky overflow; empty flag kept beside it
// - top address register reads and writes top, all ones when empty
// - count stack always holds as many entries as address stack
// - current count is top count entry, all ones when empty
// - count decrements at e-2 in longer loops, at the end in one- and two-instruction loops
// - current count write changes running counted loop, else ignored
// - next count addresses slot above top; zero means 2^32 passes
// - counted setup pushes next count, keeping old current below
// - next count reads invalid and writes are dropped when full
// - long loops test at e-2: false loops back, true exits and pops
package zls_pkg;
   localparam int DEPTH   = 6;
   localparam int LVL_W   = 3;
   localparam int WORD_W  = 32;
   localparam int ADDR_W  = 24;
   localparam int END_HI  = 23;
   localparam int CODE_LO = 24;
   localparam int CODE_HI = 28;
   localparam int RSV_BIT = 29;
   localparam int TYPE_LO = 30;
   localparam int TYPE_HI = 31;

   localparam logic [1:0] TYPE_COND = 2'h0;
   localparam logic [1:0] TYPE_CNT1 = 2'h1;
   localparam logic [1:0] TYPE_CNT2 = 2'h2;
   localparam logic [1:0] TYPE_CNTN = 2'h3;

   localparam logic [1:0] LEN_1    = 2'h0;
   localparam logic [1:0] LEN_2    = 2'h1;
   localparam logic [1:0] LEN_3    = 2'h2;
   localparam logic [1:0] LEN_LONG = 2'h3;

   localparam logic [4:0] CODE_COUNT_EXPIRED = 5'h0f;

   localparam logic [WORD_W-1:0] ALL_ONES  = 32'hffff_ffff;
   localparam logic [WORD_W-1:0] CNT_ONE   = 32'h0000_0001;
   localparam logic [WORD_W-1:0] CNT_TWO   = 32'h0000_0002;
   localparam logic [WORD_W-1:0] CNT_THREE = 32'h0000_0003;
   localparam logic [WORD_W-1:0] NLC_RESET = 32'h0000_0001;
   localparam logic [WORD_W-1:0] RSV_MASK  = 32'hdfff_ffff;

   localparam logic [ADDR_W-1:0] DIST_ONE   = 24'h00_0001;
   localparam logic [ADDR_W-1:0] DIST_TWO   = 24'h00_0002;
   localparam logic [ADDR_W-1:0] DIST_THREE = 24'h00_0003;

   localparam logic [LVL_W-1:0] LVL_ONE = 3'h1;

   localparam logic [1:0] SEL_TOP_ADDR = 2'h0;
   localparam logic [1:0] SEL_CUR_CNT  = 2'h1;
   localparam logic [1:0] SEL_NEXT_CNT = 2'h2;

   localparam logic [1:0] PASSES_LEN1 = 2'h3;
   localparam logic [1:0] PASSES_LEN2 = 2'h1;
   localparam logic [1:0] REM_ONE     = 2'h1;
   localparam logic [1:0] REM_ZERO    = 2'h0;

   typedef enum logic [1:0] {
      ZLS_IDLE  = 2'b00,
      ZLS_RUN   = 2'b01,
      ZLS_FINAL = 2'b11,
      ZLS_DRAIN = 2'b10
   } zls_state_t;
endpackage

// ### verilog/zls_sequencer.sv
/*
 Zero overhead loop sequencer: loop address and count stacks, loop end
 decisions for long and short loops, interrupt hold and abort requests.
 Assumes the pipeline reports the executing address each cycle, evaluates
 the termination code into cond_true, and owns the PC stack.
*/
`timescale 1ns/10ps
module zls_sequencer
   import zls_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              nrst,
   input  wire logic              exec_valid,
   input  wire logic [ADDR_W-1:0] exec_pc,
   input  wire logic              cond_true,
   input  wire logic              setup_start,
   input  wire logic              push_loop,
   input  wire logic              pop_loop,
   input  wire logic              abort_jump,
   input  wire logic [ADDR_W-1:0] setup_pc,
   input  wire logic [ADDR_W-1:0] setup_end,
   input  wire logic [4:0]        setup_code,
   input  wire logic [1:0]        reg_sel,
   input  wire logic              reg_rd,
   input  wire logic              reg_wr,
   input  wire logic [WORD_W-1:0] reg_wdata,
   input  wire logic              sticky_clear_overflow,
   output logic      [WORD_W-1:0] reg_rdata,
   output logic                   loop_back,
   output logic                   loop_exit,
   output logic                   squash,
   output logic                   irq_hold,
   output logic                   count_expired_condition,
   output logic                   sticky_overflow,
   output logic                   sticky_empty
);
   // ----------------------------------------------------------------
   // stacks
   // ----------------------------------------------------------------
   zls_stk_if #(.W(WORD_W), .LW(LVL_W)) astk ();
   zls_stk_if #(.W(WORD_W), .LW(LVL_W)) cstk ();

   zls_stack #(.W(WORD_W), .DEPTH(DEPTH), .LW(LVL_W)) u_addr_stack (
      .clock (clock),
      .nrst  (nrst),
      .s     (astk.stack)
   );
   zls_stack #(.W(WORD_W), .DEPTH(DEPTH), .LW(LVL_W)) u_count_stack (
      .clock (clock),
      .nrst  (nrst),
      .s     (cstk.stack)
   );

   zls_state_t        state, next_state;
   logic [1:0]        top_len, next_len, rem, next_rem;
   logic [1:0]        top_type, cls, setup_type, setup_cls;
   logic [WORD_W-1:0] nlc, next_nlc, next_rdata, count;
   logic [ADDR_W-1:0] top_end, setup_len;
   logic              few, next_few, next_loop_back, next_overflow;
   logic              exit_now, squash_now, hold_now, expire_now, dec_now;
   logic              pop_now, push_now, active, is_cnt, wr_cur;
   logic              setup_cnt, setup_few, at_e2, at_end;

   assign active   = !astk.empty;
   assign top_type = astk.top[TYPE_HI:TYPE_LO];
   assign top_end  = astk.top[END_HI:0];
   assign count    = cstk.top;
   assign is_cnt   = (top_type != TYPE_COND);
   assign at_e2    = exec_valid && (exec_pc == top_end - DIST_TWO);
   assign at_end   = exec_valid && (exec_pc == top_end);
   assign push_now = setup_start || push_loop;

   // ----------------------------------------------------------------
   // classify the loop being set up
   // ----------------------------------------------------------------
   assign setup_len = setup_end - setup_pc;
   assign setup_cnt = (setup_code == CODE_COUNT_EXPIRED);

   always_comb begin
      case (setup_len)
         DIST_ONE:   setup_cls = LEN_1;
         DIST_TWO:   setup_cls = LEN_2;
         DIST_THREE: setup_cls = LEN_3;
         default:    setup_cls = LEN_LONG;
      endcase
      if (!setup_cnt) begin
         setup_type = TYPE_COND;
      end else if (setup_cls == LEN_1) begin
         setup_type = TYPE_CNT1;
      end else if (setup_cls == LEN_2) begin
         setup_type = TYPE_CNT2;
      end else begin
         setup_type = TYPE_CNTN;
      end
      // few passes decide the two-cycle abort, fixed at setup
      setup_few = setup_cnt &&
                  (((setup_cls == LEN_1) &&
                    ((nlc == CNT_ONE) || (nlc == CNT_TWO))) ||
                   ((setup_cls == LEN_2) && (nlc == CNT_ONE)));
   end

   // counted loops carry their length in the type field
   always_comb begin
      case (top_type)
         TYPE_CNT1: cls = LEN_1;
         TYPE_CNT2: cls = LEN_2;
         TYPE_CNTN: cls = LEN_LONG;
         default:   cls = top_len;
      endcase
   end

   // ----------------------------------------------------------------
   // loop end decisions
   // ----------------------------------------------------------------
   always_comb begin
      next_state     = state;
      next_len       = top_len;
      next_few       = few;
      next_rem       = rem;
      next_loop_back = 1'b0;
      exit_now       = 1'b0;
      squash_now     = 1'b0;
      hold_now       = 1'b0;
      expire_now     = 1'b0;
      dec_now        = 1'b0;
      if (state == ZLS_DRAIN) begin
         next_state = active ? ZLS_RUN : ZLS_IDLE;
      end
      if (active) begin
         case (cls)
            LEN_LONG: begin
               if (at_e2) begin
                  if (is_cnt) begin
                     dec_now    = 1'b1;
                     expire_now = (count == CNT_ONE);
                     exit_now   = expire_now;
                  end else begin
                     exit_now = cond_true;
                  end
                  next_loop_back = !exit_now;
               end
            end
            LEN_3: begin
               // tested at the top instruction, then one whole pass
               if (at_e2) begin
                  if (state == ZLS_FINAL) begin
                     exit_now = 1'b1;
                  end else if (cond_true) begin
                     next_state = ZLS_FINAL;
                  end
                  next_loop_back = !exit_now;
               end
            end
            default: begin
               if (at_end && is_cnt) begin
                  dec_now    = 1'b1;
                  expire_now = (count == CNT_ONE);
                  exit_now   = expire_now;
                  if (few && expire_now) begin
                     squash_now = 1'b1;
                     hold_now   = 1'b1;
                  end
                  if (!few && (cls == LEN_1) && (count == CNT_THREE)) begin
                     hold_now = 1'b1;
                  end
                  next_loop_back = !exit_now;
               end else if (at_end) begin
                  // condition seen at the end instruction starts the count
                  if (state == ZLS_FINAL) begin
                     if (rem == REM_ONE) begin
                        exit_now = 1'b1;
                     end else begin
                        next_rem = rem - REM_ONE;
                     end
                  end else if (cond_true) begin
                     next_state = ZLS_FINAL;
                     next_rem   = (cls == LEN_1) ? PASSES_LEN1
                                                 : PASSES_LEN2;
                  end
                  next_loop_back = !exit_now;
               end
            end
         endcase
      end
      // loop abort pops a single level only
      pop_now = exit_now || ((pop_loop || abort_jump) && active);
      if (pop_now) begin
         // an enclosing loop is never short, so assume long
         next_len = LEN_LONG;
         next_few = 1'b0;
         next_rem = REM_ZERO;
         if (squash_now) begin
            next_state = ZLS_DRAIN;
         end else if (astk.level > LVL_ONE) begin
            next_state = ZLS_RUN;
         end else begin
            next_state = ZLS_IDLE;
         end
      end
      if (push_now) begin
         next_state = ZLS_RUN;
         next_len   = setup_cls;
         next_few   = setup_few;
         next_rem   = REM_ZERO;
      end
   end

   // ----------------------------------------------------------------
   // stack requests
   // ----------------------------------------------------------------
   // sequencer decrement wins over a software write in the same cycle
   assign wr_cur = reg_wr && (reg_sel == SEL_CUR_CNT) && active && is_cnt;

   assign astk.push   = push_now;
   assign astk.pop    = pop_now;
   assign astk.din    = {setup_type, 1'b0, setup_code, setup_end};
   assign astk.wr_top = reg_wr && (reg_sel == SEL_TOP_ADDR);
   assign astk.wdata  = reg_wdata & RSV_MASK;

   assign cstk.push   = push_now;
   assign cstk.pop    = pop_now;
   assign cstk.din    = nlc;
   assign cstk.wr_top = dec_now || wr_cur;
   // zero wraps to all ones, giving the full 2^32 passes
   assign cstk.wdata  = dec_now ? (count - CNT_ONE) : reg_wdata;

   // ----------------------------------------------------------------
   // register reads and next count
   // ----------------------------------------------------------------
   always_comb begin
      next_nlc = nlc;
      if (reg_wr && (reg_sel == SEL_NEXT_CNT) && !cstk.full) begin
         next_nlc = reg_wdata;
      end
      next_rdata = reg_rdata;
      if (reg_rd) begin
         case (reg_sel)
            SEL_TOP_ADDR: next_rdata = active ? astk.top : ALL_ONES;
            SEL_CUR_CNT:  next_rdata = active ? count : ALL_ONES;
            SEL_NEXT_CNT: next_rdata = cstk.full ? ALL_ONES : nlc;
            default:      next_rdata = '0;
         endcase
      end
      // set wins over a clear arriving together
      next_overflow = astk.overflow ||
                      (sticky_overflow && !sticky_clear_overflow);
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         state                   <= ZLS_IDLE;
         top_len                 <= LEN_LONG;
         few                     <= 1'b0;
         rem                     <= REM_ZERO;
         nlc                     <= NLC_RESET;
         reg_rdata               <= '0;
         loop_back               <= 1'b0;
         loop_exit               <= 1'b0;
         squash                  <= 1'b0;
         irq_hold                <= 1'b0;
         count_expired_condition <= 1'b0;
         sticky_overflow         <= 1'b0;
         sticky_empty            <= 1'b1;
      end else begin
         state                   <= next_state;
         top_len                 <= next_len;
         few                     <= next_few;
         rem                     <= next_rem;
         nlc                     <= next_nlc;
         reg_rdata               <= next_rdata;
         loop_back               <= next_loop_back;
         loop_exit               <= exit_now;
         squash                  <= squash_now;
         irq_hold                <= hold_now || (state == ZLS_DRAIN);
         count_expired_condition <= expire_now;
         sticky_overflow         <= next_overflow;
         sticky_empty            <= astk.empty;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   AST_OVF_STICKY: assert property (
      (astk.push && astk.full && !astk.pop) |=> sticky_overflow)
      else $error("overflow flag not set by full push");
   AST_TOP_EMPTY: assert property (
      (reg_rd && reg_sel == SEL_TOP_ADDR && astk.empty)
      |=> (reg_rdata == ALL_ONES))
      else $error("empty top address not all ones");
   AST_CNT_EMPTY: assert property (
      (reg_rd && reg_sel == SEL_CUR_CNT && cstk.empty)
      |=> (reg_rdata == ALL_ONES))
      else $error("empty current count not all ones");
   AST_NLC_FULL: assert property (
      (reg_wr && reg_sel == SEL_NEXT_CNT && cstk.full) |=> (nlc == $past(nlc)))
      else $error("next count written while full");
   AST_STACK_SYNC: assert property (
      astk.level == cstk.level)
      else $error("address and count stacks out of step");
   AST_ABORT_POP: assert property (
      (abort_jump && active && !push_now)
      |=> (astk.level == $past(astk.level) - LVL_ONE))
      else $error("loop abort did not pop one level");
   AST_SQUASH_HOLD: assert property (
      squash |-> irq_hold ##1 irq_hold)
      else $error("abort cycles without interrupt hold");
   AST_EXPIRE_EXIT: assert property (
      count_expired_condition |-> (loop_exit && !loop_back))
      else $error("count expired without loop exit");
   AST_RSV_ZERO: assert property (
      (reg_rd && reg_sel == SEL_TOP_ADDR && active) |=> !reg_rdata[RSV_BIT])
      else $error("reserved address bit read as one");
   AST_DEC: assert property (
      (dec_now && !pop_now && !push_now)
      |=> (cstk.top == $past(count) - CNT_ONE))
      else $error("count not decremented");
   AST_LONG_BACK: assert property (
      (active && cls == LEN_LONG && !is_cnt && at_e2 && !cond_true &&
       !pop_loop && !abort_jump) |=> (loop_back && !loop_exit))
      else $error("long loop did not loop back");
   AST_HOLD_THIRD: assert property (
      (active && cls == LEN_1 && is_cnt && !few && at_end &&
       count == CNT_THREE) |=> irq_hold)
      else $error("third-to-last pass without hold");
   AST_PUSH_COUNT: assert property (
      (setup_start && !cstk.full && !pop_now) |=> (cstk.top == $past(nlc)))
      else $error("setup did not push next count");

   COV_SQUASH: cover property (squash);
   COV_OVERFLOW: cover property (sticky_overflow);
   COV_COND_EXIT: cover property (state == ZLS_FINAL ##[1:20] loop_exit);
   COV_NESTED: cover property (astk.level > LVL_ONE ##[1:50] loop_exit);
endmodule

// ### verilog/zls_stack.sv
/*
 Fixed depth LIFO with top write, used for loop address and count stacks.
 Assumes the user never relies on data at or above the level count.
*/
`timescale 1ns/10ps
module zls_stack
   import zls_pkg::*;
#(
   parameter int W     = 32,
   parameter int DEPTH = 6,
   parameter int LW    = 3
) (
   input wire logic clock,
   input wire logic nrst,
   zls_stk_if.stack s
);
   localparam logic [LW-1:0] ONE  = LW'(1);
   localparam logic [LW-1:0] FULL = LW'(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [W-1:0]  next_mem [DEPTH];
   logic [LW-1:0] level;
   logic [LW-1:0] next_level;
   logic [LW-1:0] top_idx;

   assign top_idx    = level - ONE;
   assign s.level    = level;
   assign s.empty    = (level == '0);
   assign s.full     = (level == FULL);
   assign s.top      = s.empty ? '0 : mem[top_idx];
   assign s.overflow = s.push && s.full && !s.pop;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_level = level;
      next_mem   = mem;
      if (s.pop && !s.empty) begin
         // pop and push together replace the top in place
         if (s.push) begin
            next_mem[top_idx] = s.din;
         end else begin
            next_level = top_idx;
         end
      end else if (s.push && !s.full) begin
         next_mem[level] = s.din;
         next_level      = level + ONE;
      end else if (s.wr_top && !s.empty) begin
         next_mem[top_idx] = s.wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         level <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
      end else begin
         level <= next_level;
         mem   <= next_mem;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_STK_PUSH: assert property (@(posedge clock) disable iff (!nrst)
      (s.push && !s.full && !s.pop) |=> (level == $past(level) + ONE))
      else $error("stack push did not raise level");
   AST_STK_BOUND: assert property (@(posedge clock) disable iff (!nrst)
      (s.push && s.full && !s.pop) |=> (level == FULL))
      else $error("stack level passed its depth");
   COV_STK_FULL: cover property (@(posedge clock) disable iff (!nrst)
      s.push && s.full);
endmodule

// ### verilog/zls_stk_if.sv
/*
 Carrier between the sequencer and one of its loop stacks.
 Assumes both ends sit on the core clock.
*/
`timescale 1ns/10ps
interface zls_stk_if #(
   parameter int W  = 32,
   parameter int LW = 3
);
   logic          push;
   logic          pop;
   logic          wr_top;
   logic [W-1:0]  din;
   logic [W-1:0]  wdata;
   logic [W-1:0]  top;
   logic [LW-1:0] level;
   logic          full;
   logic          empty;
   logic          overflow;

   modport stack (
      input  push,
      input  pop,
      input  wr_top,
      input  din,
      input  wdata,
      output top,
      output level,
      output full,
      output empty,
      output overflow
   );
   modport user (
      output push,
      output pop,
      output wr_top,
      output din,
      output wdata,
      input  top,
      input  level,
      input  full,
      input  empty,
      input  overflow
   );
endinterface
